// *** logic/reset_strap_pin_function_mux.sv ***
// Reset strap capture and hand-over of the shared pins to pin I/O and SPI roles.
`timescale 1ns/1ps
`include "strap_mux_regs.svh"
module reset_strap_pin_function_mux
  import strap_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Multipurpose pins, also config straps 0..2 and test strap
  input  wire logic [`MP_PIN_COUNT-1:0] multipurpose_pin_in,
  output logic      [`MP_PIN_COUNT-1:0] multipurpose_pin_out,
  output logic      [`MP_PIN_COUNT-1:0] multipurpose_pin_oe_n,
  // Select pin, also interface strap bit 0
  input  wire logic                     spi_select_low_in,
  output logic                          spi_select_low_out,
  output logic                          spi_select_low_oe_n,
  // Slave data out pin, also interface strap bit 1
  input  wire logic                     miso_in,
  output logic                          miso_out,
  output logic                          miso_oe_n,
  // Pin configuration
  input  wire logic [3:0]               pin_config_reg_a,
  input  wire logic [1:0]               pin2_config_field,
  input  wire logic [1:0]               pin3_config_field,
  input  wire logic [`MP_PIN_COUNT-1:0] latch_clear,
  // SPI core side
  input  wire logic                     autocfg_active,
  input  wire logic                     eeprom_select_low,
  input  wire logic                     slave_miso_data,
  input  wire logic                     slave_miso_drive,
  output logic                          core_select_low,
  output logic                          core_miso,
  // Status
  output strap_s                        straps,
  output logic                          run_phase,
  output pin_status_s                   pin_state_reg
);

  phase_e    phase;
  phase_e    next_phase;
  logic      spi_master;
  logic      spi_slave;
  logic [1:0] pin_mode [`MP_PIN_COUNT];

  // ------------------------------------------------------------------
  // Phase control
  // ------------------------------------------------------------------
  // The flops take only constants under reset; the straps are read at the first edge after release.
  always_comb begin
    case (phase)
      ST_STRAP: next_phase = ST_RUN;
      ST_RUN:   next_phase = ST_RUN;
      default:  next_phase = ST_STRAP;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ST_STRAP;
    end else begin
      phase <= next_phase;
    end
  end

  assign run_phase = (phase == ST_RUN);

  // ------------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------------
  // Captured once; later pin traffic cannot disturb the stored mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      straps <= '0;
    end else if (phase == ST_STRAP) begin
      straps.iface_mode          <= {miso_in, spi_select_low_in};
      straps.config_select_strap <= multipurpose_pin_in[`CFG_SEL_WIDTH-1:0];
      straps.factory_test        <= multipurpose_pin_in[`TEST_PIN_INDEX];
    end
  end

  assign spi_master = (straps.iface_mode == `IFACE_SPI_MASTER);
  assign spi_slave  = (straps.iface_mode == `IFACE_SPI_SLAVE);

  // ------------------------------------------------------------------
  // Multipurpose pins
  // ------------------------------------------------------------------
  assign pin_mode[0] = pin_config_reg_a[`CFG_A_PIN0_LSB +: 2];
  assign pin_mode[1] = pin_config_reg_a[`CFG_A_PIN1_LSB +: 2];
  assign pin_mode[2] = pin2_config_field;
  assign pin_mode[3] = pin3_config_field;

  for (genvar i = 0; i < `MP_PIN_COUNT; i++) begin : g_pin
    mp_pin_cell u_cell (
      .clk         (clk),
      .rst_n       (rst_n),
      .run         (run_phase),
      .mode        (pin_mode[i]),
      .latch_clear (latch_clear[i]),
      .pin_in      (multipurpose_pin_in[i]),
      .pin_out     (multipurpose_pin_out[i]),
      .pin_oe_n    (multipurpose_pin_oe_n[i]),
      .live        (pin_state_reg.live[i]),
      .latched     (pin_state_reg.latched[i])
    );
  end

  // ------------------------------------------------------------------
  // Select pin
  // ------------------------------------------------------------------
  // Driven only while a master-mode auto-configuration runs; the board must pull it otherwise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_select_low_oe_n <= 1'b1;
      spi_select_low_out  <= 1'b1;
    end else if (run_phase && spi_master && autocfg_active) begin
      spi_select_low_oe_n <= 1'b0;
      spi_select_low_out  <= eeprom_select_low;
    end else begin
      spi_select_low_oe_n <= 1'b1;
      spi_select_low_out  <= 1'b1;
    end
  end

  // Select seen by the core; before the straps are taken it reads idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_select_low <= 1'b1;
    end else begin
      core_select_low <= run_phase ? spi_select_low_in : 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Slave data out pin
  // ------------------------------------------------------------------
  // As slave the line drives only during a selected access; as master it is an input.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_oe_n <= 1'b1;
      miso_out  <= 1'b0;
      core_miso <= 1'b0;
    end else begin
      miso_oe_n <= !(run_phase && spi_slave && slave_miso_drive && !spi_select_low_in);
      miso_out  <= slave_miso_data;
      core_miso <= miso_in;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_release;
    phase == ST_STRAP ##1 phase == ST_RUN;
  endsequence

  chk_iface_capture: assert property (@(posedge clk) disable iff (!rst_n)
    s_release |-> straps.iface_mode == {$past(miso_in), $past(spi_select_low_in)})
    else $error("interface mode not taken from straps");

  chk_test_capture: assert property (@(posedge clk) disable iff (!rst_n)
    s_release |-> straps.factory_test == $past(multipurpose_pin_in[`TEST_PIN_INDEX]))
    else $error("test strap not taken");

  chk_select_capture: assert property (@(posedge clk) disable iff (!rst_n)
    s_release |-> straps.config_select_strap == $past(multipurpose_pin_in[2:0]))
    else $error("config selector not taken");

  chk_strap_hold: assert property (@(posedge clk) disable iff (!rst_n)
    run_phase && $past(run_phase) |-> $stable(straps))
    else $error("captured straps changed");

  chk_pins_input_strap: assert property (@(posedge clk) disable iff (!rst_n)
    phase == ST_STRAP |-> &multipurpose_pin_oe_n && spi_select_low_oe_n && miso_oe_n)
    else $error("shared pin driven before strap capture");

  chk_cs_master_drive: assert property (@(posedge clk) disable iff (!rst_n)
    run_phase && spi_master && autocfg_active |=>
      !spi_select_low_oe_n && spi_select_low_out == $past(eeprom_select_low))
    else $error("select not driven for eeprom access");

  chk_cs_input_normal: assert property (@(posedge clk) disable iff (!rst_n)
    run_phase && !autocfg_active |=> spi_select_low_oe_n)
    else $error("select not released to input");

  chk_miso_slave: assert property (@(posedge clk) disable iff (!rst_n)
    run_phase && spi_slave && slave_miso_drive && !spi_select_low_in |=> !miso_oe_n)
    else $error("slave data line not driven");

  chk_miso_master: assert property (@(posedge clk) disable iff (!rst_n)
    spi_master |=> miso_oe_n)
    else $error("data line driven in master mode");

  // Only a master-mode device may ever drive the select pin.
  chk_cs_slave_input: assert property (@(posedge clk) disable iff (!rst_n)
    !spi_master |=> spi_select_low_oe_n)
    else $error("select driven outside master mode");

  // Before the straps are taken the core must see an idle select.
  chk_core_select_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !run_phase |=> core_select_low)
    else $error("core select not idle before capture");

  // After capture the core sees the select pin one cycle late.
  chk_core_select_pass: assert property (@(posedge clk) disable iff (!rst_n)
    run_phase |=> core_select_low == $past(spi_select_low_in))
    else $error("core select does not follow pin");
endmodule

// *** logic/strap_mux_regs.svh ***
// Field positions, encodings and widths shared by the strap and pin-function logic.
`ifndef STRAP_MUX_REGS_SVH
`define STRAP_MUX_REGS_SVH

// ------------------------------------------------------------------
// Pin counts, widths and indices
// ------------------------------------------------------------------
`define MP_PIN_COUNT      4
`define CFG_SEL_WIDTH     3
`define TEST_PIN_INDEX    3

// ------------------------------------------------------------------
// Interface mode codes, from {iface_strap_bit1, iface_strap_bit0}
// ------------------------------------------------------------------
`define IFACE_I2C_SLAVE   2'h0
`define IFACE_SPI_SLAVE   2'h1
`define IFACE_SPI_MASTER  2'h2
`define IFACE_RESERVED    2'h3

// ------------------------------------------------------------------
// Multipurpose pin configuration field codes
// ------------------------------------------------------------------
`define PIN_MODE_INPUT    2'h0
`define PIN_MODE_DRV_LOW  2'h1
`define PIN_MODE_DRV_HIGH 2'h2
`define PIN_MODE_INPUT_B  2'h3

// ------------------------------------------------------------------
// Field positions inside pin_config_reg_a
// ------------------------------------------------------------------
`define CFG_A_PIN0_LSB    0
`define CFG_A_PIN1_LSB    2

`endif

// *** logic/strap_mux_pkg.sv ***
// Types shared by the strap capture and pin-function logic.
package strap_mux_pkg;
  `include "strap_mux_regs.svh"

  // ------------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_INPUT    = `PIN_MODE_INPUT,
    PIN_DRV_LOW  = `PIN_MODE_DRV_LOW,
    PIN_DRV_HIGH = `PIN_MODE_DRV_HIGH,
    PIN_INPUT_B  = `PIN_MODE_INPUT_B
  } pin_mode_e;

  typedef enum logic {
    ST_STRAP = 1'b0,
    ST_RUN   = 1'b1
  } phase_e;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                  iface_mode;
    logic [`CFG_SEL_WIDTH-1:0]   config_select_strap;
    logic                        factory_test;
  } strap_s;

  typedef struct packed {
    logic [`MP_PIN_COUNT-1:0] live;
    logic [`MP_PIN_COUNT-1:0] latched;
  } pin_status_s;
endpackage

// *** logic/mp_pin_cell.sv ***
// One multipurpose pin: direction and level from its field, live and latched status.
`timescale 1ns/1ps
module mp_pin_cell
  import strap_mux_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  input  wire logic [1:0] mode,
  input  wire logic latch_clear,
  // Pin
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  // Status
  output logic      live,
  output logic      latched
);

  logic prev_level;
  logic edge_seen;

  // ------------------------------------------------------------------
  // Pin driver
  // ------------------------------------------------------------------
  // The pin stays an input until the straps are taken, so board strap levels are never fought.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_n <= 1'b1;
      pin_out  <= 1'b0;
    end else if (run) begin
      pin_oe_n <= !(mode == PIN_DRV_LOW || mode == PIN_DRV_HIGH);
      pin_out  <= (mode == PIN_DRV_HIGH);
    end else begin
      pin_oe_n <= 1'b1;
      pin_out  <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Status
  // ------------------------------------------------------------------
  // Live level is the pin one cycle late; latched catches any change while run is high.
  assign edge_seen = run && (pin_in != prev_level);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live       <= 1'b0;
      prev_level <= 1'b0;
    end else begin
      live       <= pin_in;
      prev_level <= pin_in;
    end
  end

  // A change arriving with the clear still sets the bit, so no event is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 1'b0;
    end else if (edge_seen) begin
      latched <= 1'b1;
    end else if (latch_clear) begin
      latched <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_pin_drive_high: assert property (@(posedge clk) disable iff (!rst_n)
    run && mode == PIN_DRV_HIGH |=> !pin_oe_n && pin_out)
    else $error("pin not driven high in drive-high mode");

  chk_latch_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    edge_seen |=> latched)
    else $error("pin change not latched");
endmodule

// *** verification/board_host_model.sv ***
// Board and host model around the shared pins: strap levels, pin drive and select level.
`timescale 1ns/1ps
module board_host_model
  import strap_mux_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Levels the board and host want on the pins
  input  wire logic [3:0] board_pins,
  input  wire logic       host_select_low,
  input  wire logic       strap_miso,
  // Drive from the block
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  input  wire logic       sel_out,
  input  wire logic       sel_oe_n,
  input  wire logic       miso_out,
  input  wire logic       miso_oe_n,
  // Resolved wire levels
  output logic      [3:0] pin_wire,
  output logic            sel_wire,
  output logic            miso_wire
);
  logic [1:0] hold;
  logic       toggle;

  // ------------------------------------------------------------------
  // Strap hold and floating pattern
  // ------------------------------------------------------------------
  // The miso strap resistor is only trusted up to the edge after the capture edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 2'h3;
    end else begin
      hold <= {hold[0], 1'b0};
    end
  end

  // A released line shows a changing pattern so a stale value cannot pass.
  // Reset keeps the pattern known, so an unknown line can never match an unknown expectation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
    end
  end

  // ------------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------------
  // The board pulls every multipurpose pin to its wanted level when undriven.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_wire[i] = pin_oe_n[i] ? board_pins[i] : pin_out[i];
    end
  end
  // The host holds select at a defined level whenever the block leaves it undriven, and pulls it low to access.
  assign sel_wire  = sel_oe_n ? host_select_low : sel_out;
  assign miso_wire = !miso_oe_n ? miso_out : (hold[1] ? strap_miso : toggle);
endmodule

// *** verification/tb_reset_strap_pin_function_mux.sv ***
// Self-checking bench for the strap capture and pin hand-over block.
`timescale 1ns/1ps
module tb_reset_strap_pin_function_mux
  import strap_mux_pkg::*;
;
  logic        clk, rst_n, host_sel, strap_miso, autocfg, eeprom_sel, sdata, sdrive;
  logic [3:0]  board_pins, cfg_a, pin_out, pin_oe_n, pin_wire, latch_clear, m_oe, m_out, m_live, m_lat;
  logic [1:0]  f2, f3;
  logic [7:0]  modes;
  logic        sel_out, sel_oe_n, sel_wire, miso_out, miso_oe_n, miso_wire, core_sel, core_miso, run_phase;
  logic        m_run, m_sel_oe, m_sel_out, m_miso_oe, m_miso_out, m_core_sel, m_core_miso;
  strap_s      straps, m_straps;
  pin_status_s status;
  int          errors, total_checks, cycles;

  assign modes = {f3, f2, cfg_a};
  always #12.5 clk = ~clk;

  reset_strap_pin_function_mux u_dut (.clk(clk), .rst_n(rst_n), .multipurpose_pin_in(pin_wire),
    .multipurpose_pin_out(pin_out), .multipurpose_pin_oe_n(pin_oe_n), .spi_select_low_in(sel_wire),
    .spi_select_low_out(sel_out), .spi_select_low_oe_n(sel_oe_n), .miso_in(miso_wire), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .pin_config_reg_a(cfg_a), .pin2_config_field(f2), .pin3_config_field(f3),
    .latch_clear(latch_clear), .autocfg_active(autocfg), .eeprom_select_low(eeprom_sel),
    .slave_miso_data(sdata), .slave_miso_drive(sdrive), .core_select_low(core_sel), .core_miso(core_miso),
    .straps(straps), .run_phase(run_phase), .pin_state_reg(status));

  board_host_model u_board (.clk(clk), .rst_n(rst_n), .board_pins(board_pins), .host_select_low(host_sel),
    .strap_miso(strap_miso), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .sel_out(sel_out), .sel_oe_n(sel_oe_n),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .pin_wire(pin_wire), .sel_wire(sel_wire),
    .miso_wire(miso_wire));

  // ------------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------------
  // Mirrors the hand-over timing: straps at the first edge, drivers from the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {m_run, m_straps, m_out, m_live, m_lat, m_miso_out, m_core_miso} <= '0;
      {m_oe, m_sel_oe, m_sel_out, m_miso_oe, m_core_sel} <= '1;
    end else begin
      if (!m_run) m_straps <= {miso_wire, sel_wire, pin_wire[2:0], pin_wire[3]};
      m_run <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        m_oe[i]  <= !(m_run && (modes[2*i+:2] == 2'h1 || modes[2*i+:2] == 2'h2));
        m_out[i] <= modes[2*i+:2] == 2'h2;
        m_lat[i] <= (m_run && pin_wire[i] != m_live[i]) ? 1'b1 : (latch_clear[i] ? 1'b0 : m_lat[i]);
      end
      m_live <= pin_wire;
      m_sel_oe    <= !(m_run && m_straps.iface_mode == 2'h2 && autocfg);
      m_sel_out   <= eeprom_sel;
      m_miso_oe   <= !(m_run && m_straps.iface_mode == 2'h1 && sdrive && !sel_wire);
      m_miso_out  <= sdata;
      m_core_sel  <= m_run ? sel_wire : 1'b1;
      m_core_miso <= miso_wire;
    end
  end

  // ------------------------------------------------------------------
  // Comparisons
  // ------------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_straps();
    cmp(8'(straps), 8'(m_straps), "straps");
    cmp(8'(run_phase), 8'(m_run), "run phase");
  endtask

  task automatic check_pins();
    cmp(8'(pin_oe_n), 8'(m_oe), "pin enable");
    cmp(8'(pin_out & ~m_oe), 8'(m_out & ~m_oe), "pin level");
  endtask

  task automatic check_spi();
    cmp(8'(sel_oe_n), 8'(m_sel_oe), "select enable");
    if (!m_sel_oe) cmp(8'(sel_out), 8'(m_sel_out), "select level");
    cmp({6'h00, miso_oe_n, miso_out}, {6'h00, m_miso_oe, m_miso_out}, "miso");
    cmp({6'h00, core_sel, core_miso}, {6'h00, m_core_sel, m_core_miso}, "core side");
  endtask

  task automatic check_status();
    cmp(8'(status), {m_live, m_lat}, "pin status");
  endtask

  // Every output but the undriven pin and select levels is compared mid-cycle, also while reset is held low.
  always @(negedge clk) begin
    check_straps();
    check_pins();
    check_spi();
    check_status();
  end

  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang is cut off far beyond the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic rand_step();
    @(posedge clk);
    cfg_a       <= 4'($urandom);
    {f2, f3}    <= 4'($urandom);
    board_pins  <= 4'($urandom);
    latch_clear <= 4'($urandom);
    {host_sel, autocfg, eeprom_sel, sdata, sdrive} <= 5'($urandom);
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  // Six rounds reset mid-run, cycling through the four interface codes in turn; the last sets the test strap.
  initial begin
    {clk, rst_n, host_sel, strap_miso, autocfg, eeprom_sel, sdata, sdrive} = '0;
    {board_pins, cfg_a, f2, f3, latch_clear} = '0;
    {errors, total_checks, cycles} = '0;
    void'($urandom(44585));
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      rst_n      <= 1'b0;
      host_sel   <= k[0];
      strap_miso <= k[1];
      board_pins <= {k == 5, 3'($urandom)};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      board_pins  <= ~board_pins;
      host_sel    <= ~host_sel;
      {cfg_a, f2, f3} <= '0;
      latch_clear <= 4'hF;
      repeat (3) @(posedge clk);
      latch_clear <= 4'h0;
      repeat (40) rand_step();
    end
    report_and_stop();
  end
endmodule
